// [src/rscl_pkg.sv]
package rscl_pkg;

  // Register addresses on the core's special register bus
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_FLASH_BOUNDARY = 8'h9C;
  localparam logic [7:0] ADDR_CHIP_CONTROL = 8'h9F;
  localparam logic [7:0] ADDR_POWER_MONITOR = 8'hA3;
  localparam logic [7:0] ADDR_PROGRAM_TRIGGER = 8'hA4;
  localparam logic [7:0] ADDR_WATCHDOG_B = 8'hAB;
  localparam logic [7:0] ADDR_WATCHDOG_A = 8'hD8;
  localparam logic [7:0] ADDR_TIMED_ACCESS = 8'hC7;

  // Field positions
  localparam int BOOT_CFG_BIT = 7;
  localparam int LOCK_CFG_BIT = 1;
  localparam int DATA_FLASH_ENABLE_CFG_CFG_BIT = 0;
  localparam int SOFTWARE_RESET_BIT_BIT = 7;
  localparam int BOOT_CTL_BIT = 1;
  localparam int WDT_EN_BIT = 7;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [7:0] FLASH_BLANK = 8'hFF;
  localparam logic [7:0] CFG_ERASED = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] POWER_CTL_POR = 8'h10;
  localparam logic [7:0] POWER_CTL_KEEP = 8'h30;
  localparam logic [7:0] CHIP_CTL_MASK = 8'h67;
  localparam logic [7:0] MONITOR_MASK = 8'hFC;
  localparam logic [7:0] MONITOR_RESET = 8'h08;

  // Timed access
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam int KEY_WINDOW_MC = 3;
  localparam int CLK_PER_MC = 12;
  localparam logic [5:0] KEY_WINDOW_CYC = 6'(KEY_WINDOW_MC * CLK_PER_MC);

  // Program area
  localparam logic [15:0] PROGRAM_TOP = 16'h4000;
  localparam logic [15:0] MIN_PROGRAM = 16'h0100;
  localparam int PORT_COUNT = 4;
  localparam int RAM_DEPTH = 256;

  typedef enum logic [1:0] {
    RSCL_SRC_POWER_ON = 2'b00,
    RSCL_SRC_WATCHDOG = 2'b01,
    RSCL_SRC_SOFT_EXT = 2'b10,
    RSCL_SRC_BROWN_OUT = 2'b11
  } rscl_src_e;

  typedef struct packed {
    logic [7:0] boot_lock_config;
    logic [7:0] data_flash_start_config;
    logic [7:0] power_monitor_cfg;
    logic [7:0] watchdog_cfg;
  } rscl_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rscl_bus_s;

  typedef struct packed {
    logic req;
    logic erase_chip;
    logic program_cfg;
    logic read_flash;
    logic [1:0] cfg_index;
    logic [7:0] data;
  } rscl_prog_s;

  // Flash region decode used by the map for the data flash start output only
  function automatic logic [15:0] rscl_df_start(input logic data_flash_enable_cfg,
                                                input logic [7:0] bnd);
    rscl_df_start = data_flash_enable_cfg ? PROGRAM_TOP : {bnd, ZERO_BYTE};
  endfunction : rscl_df_start

endpackage : rscl_pkg

// [src/rscl_key_gate.sv]
`timescale 1ns/1ps
`default_nettype none
module rscl_key_gate (
  input wire logic mclk, // System clock
  input wire logic rst, // Async reset
  input wire logic key_wr, // Write to timed-access register
  input wire logic [7:0] key_data, // Byte written
  input wire logic prot_wr, // Protected register write
  output logic open_o // Protected write allowed now
);
  logic armed_reg;
  logic [5:0] cnt_reg;
  logic open_reg;
  wire logic first_w = key_wr && key_data == rscl_pkg::KEY_FIRST;
  wire logic second_w = key_wr && key_data == rscl_pkg::KEY_SECOND
                        && armed_reg;
  wire logic expired_w = cnt_reg == rscl_pkg::KEY_WINDOW_CYC;

  // Window counted from the first key; a late second key is ignored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
      cnt_reg <= 6'h00;
      open_reg <= 1'b0;
    end else begin
      armed_reg <= first_w || (armed_reg && !expired_w && !key_wr);
      cnt_reg <= first_w ? 6'h00 : (armed_reg ? cnt_reg + 6'h01 : cnt_reg);
      if (second_w) begin
        open_reg <= 1'b1;
      end else if (prot_wr || (open_reg && expired_w)) begin
        open_reg <= 1'b0;
      end
      if (second_w) begin
        cnt_reg <= 6'h00;
      end
    end
  end
  assign open_o = open_reg || second_w;
endmodule : rscl_key_gate
`default_nettype wire

// [src/rscl_scratch_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module rscl_scratch_ram (
  input wire logic mclk, // System clock
  input wire logic we, // Write enable
  input wire logic [7:0] addr, // Word index
  input wire logic [7:0] wdata, // Write data
  output logic [7:0] rdata // Registered read data
);
  logic [7:0] mem_reg [rscl_pkg::RAM_DEPTH];

  // No reset port at all: contents survive every reset
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_reg[addr] <= wdata;
    end
    rdata <= mem_reg[addr];
  end
endmodule : rscl_scratch_ram
`default_nettype wire

// [src/rscl_loader.sv]
`timescale 1ns/1ps
`default_nettype none
module rscl_loader (
  input wire logic mclk, // System clock, 125 MHz
  input wire logic rst, // Async reset, any source
  input wire logic por_evt, // Power-on reset cause
  input wire logic wdt_evt, // Watchdog reset cause
  input wire logic bod_evt, // Brown-out reset cause
  input wire logic ext_rst_pin, // External reset pin
  input wire rscl_pkg::rscl_bus_s bus, // Core register bus
  input wire rscl_pkg::rscl_prog_s prog, // Parallel programmer port
  input wire logic [7:0] flash_rdata, // Flash array read data
  input wire logic isp_rd, // In-system programming read
  input wire logic ram_we, // Scratch RAM write
  input wire logic [7:0] ram_addr, // Scratch RAM index
  input wire logic [7:0] ram_wdata, // Scratch RAM data
  output logic [7:0] bus_rdata, // Register read data
  output logic [15:0] pc_o, // Program counter
  output logic [7:0] sp_o, // Stack pointer
  output logic [31:0] ports_o, // Port output registers
  output logic int_en_o, // Interrupts enabled
  output logic timers_en_o, // Timers enabled
  output logic watchdog_enable_ctl, // Watchdog running
  output logic boot_select_ctl, // Booted from loader flash
  output logic sw_reset_req, // Software reset request
  output logic [1:0] reset_src, // Last reset source
  output logic [15:0] df_start_o, // Data flash start address
  output logic min_program_o, // Only minimal program region
  output logic [7:0] prog_rdata, // Programmer read data
  output logic [7:0] isp_rdata, // In-system read data
  output logic chip_erase_o, // Whole-array erase strobe
  output rscl_pkg::rscl_cfg_s cfg_o, // Non-volatile config bytes
  output logic [7:0] ram_rdata // Scratch RAM read data
);
  rscl_pkg::rscl_cfg_s cfg_reg;
  logic pend_sw_reg;
  logic held_reg;
  logic [7:0] power_control_reg, bnd_reg, chp_reg, power_monitor_control_reg, trg_reg, wdb_reg;
  logic [7:0] wda_reg, rdata_reg, prog_rd_reg, isp_rd_reg;
  logic [15:0] pc_reg;
  logic [7:0] sp_reg;
  logic [31:0] port_reg;
  logic int_reg, tmr_reg, erase_reg;
  logic [1:0] src_reg;
  logic [15:0] dfs_reg;
  logic minp_reg;
  logic pin_s1_reg, pin_s2_reg;
  logic boot_reg;
  logic [7:0] power_control_hold_reg;
  logic [7:0] ram_q;
  wire logic key_open;
  rscl_pkg::rscl_src_e src_next;

  wire logic locked_w = !cfg_reg.boot_lock_config[rscl_pkg::LOCK_CFG_BIT];
  wire logic data_flash_enable_cfg_w = cfg_reg.boot_lock_config[rscl_pkg::DATA_FLASH_ENABLE_CFG_CFG_BIT];
  wire logic [7:0] cfg_b0 = cfg_reg.boot_lock_config;
  wire logic [7:0] cfg_b1 = cfg_reg.data_flash_start_config;
  wire logic wr_power_control = bus.wr && bus.addr == rscl_pkg::ADDR_POWER_CONTROL;
  wire logic wr_bnd = bus.wr && bus.addr == rscl_pkg::ADDR_FLASH_BOUNDARY;
  wire logic wr_chp = bus.wr && bus.addr == rscl_pkg::ADDR_CHIP_CONTROL;
  wire logic wr_power_monitor_control = bus.wr && bus.addr == rscl_pkg::ADDR_POWER_MONITOR;
  wire logic wr_trg = bus.wr && bus.addr == rscl_pkg::ADDR_PROGRAM_TRIGGER;
  wire logic wr_wdb = bus.wr && bus.addr == rscl_pkg::ADDR_WATCHDOG_B;
  wire logic wr_wda = bus.wr && bus.addr == rscl_pkg::ADDR_WATCHDOG_A;
  wire logic wr_key = bus.wr && bus.addr == rscl_pkg::ADDR_TIMED_ACCESS;
  wire logic prot_any = wr_bnd || wr_chp || wr_power_monitor_control || wr_trg || wr_wdb
                        || wr_wda;
  wire logic prot_ok = key_open;
  wire logic soft_rst_w = pend_sw_reg || pin_s2_reg;
  wire logic soft_only_w = src_next == rscl_pkg::RSCL_SRC_SOFT_EXT
                           && !pin_s2_reg;
  wire logic boot_cfg_w = !cfg_b0[rscl_pkg::BOOT_CFG_BIT];
  // Single-byte config change refused while locked; erase overrides
  wire logic cfg_prog_ok = prog.req && prog.program_cfg && !locked_w;
  wire logic erase_w = prog.req && prog.erase_chip;

  rscl_key_gate u_key (
    .mclk(mclk),
    .rst(rst),
    .key_wr(wr_key),
    .key_data(bus.wdata),
    .prot_wr(prot_any),
    .open_o(key_open)
  );

  rscl_scratch_ram u_ram (
    .mclk(mclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_q)
  );

  // Priority: brown-out, watchdog, then power-on, else soft/external
  always_comb begin
    if (bod_evt) begin
      src_next = rscl_pkg::RSCL_SRC_BROWN_OUT;
    end else if (wdt_evt) begin
      src_next = rscl_pkg::RSCL_SRC_WATCHDOG;
    end else if (por_evt) begin
      src_next = rscl_pkg::RSCL_SRC_POWER_ON;
    end else begin
      src_next = rscl_pkg::RSCL_SRC_SOFT_EXT;
    end
  end

  // Boot bit reads back from its own unreset flop
  wire logic [7:0] chp_view = {chp_reg[7:2], boot_reg, chp_reg[0]};
  wire logic [7:0] rd_mux =
    (bus.addr == rscl_pkg::ADDR_POWER_CONTROL) ? power_control_reg :
    (bus.addr == rscl_pkg::ADDR_FLASH_BOUNDARY) ? bnd_reg :
    (bus.addr == rscl_pkg::ADDR_CHIP_CONTROL) ?
      (chp_view & rscl_pkg::CHIP_CTL_MASK) :
    (bus.addr == rscl_pkg::ADDR_POWER_MONITOR) ? power_monitor_control_reg :
    (bus.addr == rscl_pkg::ADDR_PROGRAM_TRIGGER) ? trg_reg :
    (bus.addr == rscl_pkg::ADDR_WATCHDOG_B) ? wdb_reg :
    (bus.addr == rscl_pkg::ADDR_WATCHDOG_A) ? wda_reg :
    rscl_pkg::ZERO_BYTE;

  // External pin is asynchronous to mclk; no rst, so its level has
  // settled by the first edge after release, where the boot is chosen
  always_ff @(posedge mclk) begin
    pin_s1_reg <= ext_rst_pin;
    pin_s2_reg <= pin_s1_reg;
  end

  // Non-volatile bytes; held outside rst since they model flash cells
  always_ff @(posedge mclk) begin
    if (erase_w) begin
      cfg_reg <= {4{rscl_pkg::CFG_ERASED}};
    end else if (cfg_prog_ok) begin
      unique case (prog.cfg_index)
        2'd0: cfg_reg.boot_lock_config <= prog.data & cfg_reg.boot_lock_config;
        2'd1: cfg_reg.data_flash_start_config <= prog.data;
        2'd2: cfg_reg.power_monitor_cfg <= prog.data;
        2'd3: cfg_reg.watchdog_cfg <= prog.data;
      endcase
    end
  end

  // Core state forced while any reset is applied
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_reg <= rscl_pkg::PC_RESET;
      sp_reg <= rscl_pkg::SP_RESET;
      port_reg <= {rscl_pkg::PORT_COUNT{rscl_pkg::PORT_RESET}};
      int_reg <= 1'b0;
      tmr_reg <= 1'b0;
      held_reg <= 1'b1;
      src_reg <= 2'b00;
      pend_sw_reg <= 1'b0;
    end else begin
      held_reg <= 1'b0;
      if (held_reg) begin
        src_reg <= src_next;
      end
      pc_reg <= soft_rst_w ? rscl_pkg::PC_RESET : pc_reg;
      // Set wins against the self-clear of the finished reset
      pend_sw_reg <= wr_chp && prot_ok && bus.wdata[rscl_pkg::SOFTWARE_RESET_BIT_BIT];
    end
  end

  // Shadow bits: loaded once on release, software-owned afterwards
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_control_reg <= rscl_pkg::ZERO_BYTE;
      bnd_reg <= rscl_pkg::ZERO_BYTE;
      chp_reg <= rscl_pkg::ZERO_BYTE;
      power_monitor_control_reg <= rscl_pkg::MONITOR_RESET;
      trg_reg <= rscl_pkg::ZERO_BYTE;
      wdb_reg <= rscl_pkg::ZERO_BYTE;
      wda_reg <= rscl_pkg::ZERO_BYTE;
    end else if (held_reg) begin
      bnd_reg <= cfg_b1;
      power_monitor_control_reg <= (cfg_reg.power_monitor_cfg & rscl_pkg::MONITOR_MASK)
                  | rscl_pkg::MONITOR_RESET;
      power_control_reg <= (src_next == rscl_pkg::RSCL_SRC_POWER_ON) ?
                  rscl_pkg::POWER_CTL_POR : power_control_hold_reg;
      wda_reg <= ZERO_WDT(src_next, cfg_reg.watchdog_cfg);
    end else begin
      if (wr_power_control) begin
        power_control_reg <= bus.wdata;
      end
      if (prot_ok) begin
        if (wr_bnd) bnd_reg <= bus.wdata;
        if (wr_chp) chp_reg <= bus.wdata & rscl_pkg::CHIP_CTL_MASK;
        if (wr_power_monitor_control) power_monitor_control_reg <= bus.wdata;
        if (wr_trg) trg_reg <= bus.wdata;
        if (wr_wdb) wdb_reg <= bus.wdata;
        if (wr_wda) wda_reg <= bus.wdata;
      end
    end
  end

  // Boot select sits outside rst so a software reset finds it intact
  always_ff @(posedge mclk) begin
    if (held_reg) begin
      if (!soft_only_w) begin
        boot_reg <= boot_cfg_w;
      end
    end else if (wr_chp && prot_ok) begin
      boot_reg <= bus.wdata[rscl_pkg::BOOT_CTL_BIT];
    end
  end

  // Keep bits of power_control survive non-power-on resets; tracked
  // outside rst, including a write landing on the same edge
  always_ff @(posedge mclk) begin
    if (!held_reg) begin
      power_control_hold_reg <= (wr_power_control ? bus.wdata : power_control_reg)
                       & rscl_pkg::POWER_CTL_KEEP;
    end
  end

  // Config byte by index; byte 0 sits at the top of the word
  function automatic logic [7:0] cfg_byte(input rscl_pkg::rscl_cfg_s c,
                                          input logic [1:0] i);
    unique case (i)
      2'd0: cfg_byte = c.boot_lock_config;
      2'd1: cfg_byte = c.data_flash_start_config;
      2'd2: cfg_byte = c.power_monitor_cfg;
      2'd3: cfg_byte = c.watchdog_cfg;
    endcase
  endfunction : cfg_byte

  // Shadow watchdog enable; power-on forces it off
  function automatic logic [7:0] ZERO_WDT(input rscl_pkg::rscl_src_e s,
                                          input logic [7:0] c);
    ZERO_WDT = rscl_pkg::ZERO_BYTE;
    if (s != rscl_pkg::RSCL_SRC_POWER_ON) begin
      ZERO_WDT[rscl_pkg::WDT_EN_BIT] = !c[rscl_pkg::WDT_EN_BIT];
    end
  endfunction : ZERO_WDT

  wire logic [15:0] dfs_w = rscl_pkg::rscl_df_start(data_flash_enable_cfg_w, bnd_reg);
  wire logic minp_w = !data_flash_enable_cfg_w && bnd_reg == rscl_pkg::ZERO_BYTE;

  // Outputs and read paths, all registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg <= rscl_pkg::ZERO_BYTE;
      prog_rd_reg <= rscl_pkg::FLASH_BLANK;
      isp_rd_reg <= rscl_pkg::ZERO_BYTE;
      dfs_reg <= rscl_pkg::PROGRAM_TOP;
      minp_reg <= 1'b0;
      erase_reg <= 1'b0;
    end else begin
      rdata_reg <= bus.rd ? rd_mux : rdata_reg;
      if (prog.req && prog.read_flash) begin
        prog_rd_reg <= locked_w ? rscl_pkg::FLASH_BLANK : flash_rdata;
      end else if (prog.req) begin
        prog_rd_reg <= cfg_byte(cfg_reg, prog.cfg_index);
      end
      if (isp_rd) begin
        isp_rd_reg <= flash_rdata;
      end
      dfs_reg <= dfs_w;
      minp_reg <= minp_w;
      erase_reg <= erase_w;
    end
  end

  assign bus_rdata = rdata_reg;
  assign pc_o = pc_reg;
  assign sp_o = sp_reg;
  assign ports_o = port_reg;
  assign int_en_o = int_reg;
  assign timers_en_o = tmr_reg;
  assign watchdog_enable_ctl = wda_reg[rscl_pkg::WDT_EN_BIT];
  assign boot_select_ctl = boot_reg;
  assign sw_reset_req = pend_sw_reg;
  assign reset_src = src_reg;
  assign df_start_o = dfs_reg;
  assign min_program_o = minp_reg;
  assign prog_rdata = prog_rd_reg;
  assign isp_rdata = isp_rd_reg;
  assign chip_erase_o = erase_reg;
  assign cfg_o = cfg_reg;
  assign ram_rdata = ram_q;
  // programmer keeps reserved bits; bit-AND programming never sets them
endmodule : rscl_loader
`default_nettype wire

// [verification/rscl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module rscl_chk (
  input wire logic mclk, // System clock
  input wire logic rst, // Async reset
  input wire rscl_pkg::rscl_bus_s bus, // Core register bus
  input wire rscl_pkg::rscl_prog_s prog, // Programmer port
  input wire logic [7:0] flash_rdata, // Array data
  input wire logic isp_rd, // In-system read
  input wire logic [15:0] pc_o, // Program counter
  input wire logic [7:0] sp_o, // Stack pointer
  input wire logic [31:0] ports_o, // Port outputs
  input wire logic int_en_o, // Interrupt enable
  input wire logic timers_en_o, // Timer enable
  input wire logic watchdog_enable_ctl, // Watchdog running
  input wire logic sw_reset_req, // Soft reset request
  input wire logic [1:0] reset_src, // Reset source
  input wire logic [7:0] prog_rdata, // Programmer data
  input wire logic [7:0] isp_rdata, // In-system data
  input wire logic chip_erase_o, // Erase strobe
  input wire rscl_pkg::rscl_cfg_s cfg_o // Config bytes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Reset values seen at the first edge after release
  property p_pc_hold; $past(rst) |-> pc_o == rscl_pkg::PC_RESET; endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("pc not zero after reset");
  property p_sp_load; $past(rst) |-> sp_o == rscl_pkg::SP_RESET; endproperty
  a_sp_load: assert property (p_sp_load)
    else $error("sp not seven after reset");
  property p_ports_high;
    $past(rst) |-> ports_o == {4{rscl_pkg::PORT_RESET}};
  endproperty
  a_ports_high: assert property (p_ports_high)
    else $error("ports not all ones after reset");
  property p_irq_off; $past(rst) |-> !int_en_o && !timers_en_o; endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupts or timers on after reset");
  property p_wdt_por;
    $past(rst, 2) && !$past(rst) && reset_src == 2'h0 |-> !watchdog_enable_ctl;
  endproperty
  a_wdt_por: assert property (p_wdt_por)
    else $error("watchdog on after power-on");
  property p_lock_read;
    prog.req && prog.read_flash && !cfg_o[25] |=> prog_rdata == 8'hFF;
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("locked flash read not blank");
  property p_open_read;
    prog.req && prog.read_flash && cfg_o[25] |=>
      prog_rdata == $past(flash_rdata);
  endproperty
  a_open_read: assert property (p_open_read)
    else $error("unlocked flash read wrong");
  property p_lock_cfg;
    prog.req && prog.program_cfg && !cfg_o[25] |=> $stable(cfg_o);
  endproperty
  a_lock_cfg: assert property (p_lock_cfg)
    else $error("locked config changed");
  property p_erase;
    prog.req && prog.erase_chip |=>
      (cfg_o == 32'hFFFF_FFFF) ##[0:1] chip_erase_o;
  endproperty
  a_erase: assert property (p_erase)
    else $error("chip erase incomplete");
  property p_isp; isp_rd |=> isp_rdata == $past(flash_rdata); endproperty
  a_isp: assert property (p_isp)
    else $error("in-system read wrong");
  property p_sw_pulse;
    sw_reset_req |-> $past(bus.wr) && $past(bus.wdata[7]) &&
      $past(bus.addr) == rscl_pkg::ADDR_CHIP_CONTROL ##1 !sw_reset_req;
  endproperty
  a_sw_pulse: assert property (p_sw_pulse)
    else $error("soft reset request wrong");
endmodule : rscl_chk
bind rscl_loader rscl_chk u_chk (.mclk, .rst, .bus, .prog, .flash_rdata,
  .isp_rd, .pc_o, .sp_o, .ports_o, .int_en_o, .timers_en_o,
  .watchdog_enable_ctl, .sw_reset_req, .reset_src, .prog_rdata, .isp_rdata,
  .chip_erase_o, .cfg_o);
`default_nettype wire

// [verification/rscl_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rscl_flash_model #(
  parameter logic [7:0] FLASH_BYTE = 8'h3C // Arbitrary stored byte
) (
  input wire logic mclk, // System clock
  output logic [7:0] flash_rdata // Array read data
);
  // One fixed cell: a read has the same answer whatever edge takes it
  always_ff @(posedge mclk) begin
    flash_rdata <= FLASH_BYTE;
  end
endmodule : rscl_flash_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] FB = 8'h3C;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic por_evt = 1'b1, wdt_evt = 1'b0, bod_evt = 1'b0;
  rscl_pkg::rscl_bus_s bus = '0;
  rscl_pkg::rscl_prog_s prog = '0;
  logic isp_rd = 1'b0, ram_we = 1'b0, ext_pin = 1'b0;
  logic [7:0] ram_addr = 8'h00, ram_wdata = 8'h00, flash_rdata;
  logic [7:0] bus_rdata, sp_o, prog_rdata, isp_rdata, ram_rdata;
  logic [15:0] pc_o, df_start_o;
  logic [31:0] ports_o;
  logic int_en_o, timers_en_o, watchdog_enable_ctl, boot_select_ctl;
  logic sw_reset_req, min_program_o, chip_erase_o;
  logic [1:0] reset_src;
  rscl_pkg::rscl_cfg_s cfg_o;
  int fails = 0, n_compared = 0, cyc = 0;
  logic [7:0] rnd = 8'h35, bnd, v;
  always #4 mclk = ~mclk;
  rscl_flash_model #(.FLASH_BYTE(FB)) u_flash (.mclk(mclk),
    .flash_rdata(flash_rdata));
  rscl_loader dut (.mclk, .rst, .por_evt, .wdt_evt, .bod_evt,
    .ext_rst_pin(ext_pin), .bus, .prog, .flash_rdata, .isp_rd, .ram_we,
    .ram_addr, .ram_wdata, .bus_rdata, .pc_o, .sp_o, .ports_o, .int_en_o,
    .timers_en_o, .watchdog_enable_ctl, .boot_select_ctl, .sw_reset_req,
    .reset_src, .df_start_o, .min_program_o, .prog_rdata, .isp_rdata,
    .chip_erase_o, .cfg_o, .ram_rdata);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [15:0] df_exp(input logic en, input logic [7:0] b);
    return en ? 16'h4000 : {b, 8'h00};
  endfunction : df_exp
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(negedge mclk);
    bus.addr = a;
    bus.wdata = w;
    bus.wr = 1'b1;
    @(negedge mclk);
    bus.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge mclk);
    bus.rd = 1'b0;
  endtask : rd
  task automatic keys();
    wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_FIRST);
    wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_SECOND);
  endtask : keys
  // op bits: erase, program, flash read; none set reads a config byte
  task automatic pr(input logic [2:0] op, input logic [1:0] i,
      input logic [7:0] w);
    @(negedge mclk);
    prog = '{1'b1, op[2], op[1], op[0], i, w};
    @(negedge mclk);
    prog.req = 1'b0;
  endtask : pr
  task automatic reset_with(input logic [2:0] c);
    @(negedge mclk);
    rst = 1'b1;
    {por_evt, wdt_evt, bod_evt} = c;
    @(negedge mclk);
    chk(pc_o, 32'h0);
    chk(sp_o, 32'h07);
    chk(ports_o, 32'hFFFF_FFFF);
    chk({int_en_o, timers_en_o}, 32'h0);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    {por_evt, wdt_evt, bod_evt} = 3'h0;
  endtask : reset_with
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    por_evt = 1'b0;
    rnd = lfsr(rnd);
    v = rnd;
    ram_addr = 8'h21;
    ram_wdata = v;
    ram_we = 1'b1;
    @(negedge mclk);
    ram_we = 1'b0;
    pr(3'h4, 2'h0, 8'h00);
    chk(cfg_o, 32'hFFFF_FFFF);
    chk(chip_erase_o, 32'h1);
    rnd = lfsr(rnd);
    bnd = rnd | 8'h01;
    // Reserved bits written as ones, so they stay unprogrammed
    pr(3'h2, 2'h0, 8'h7E);
    pr(3'h2, 2'h1, bnd);
    pr(3'h2, 2'h3, 8'h7F);
    pr(3'h1, 2'h0, 8'h00);
    chk(prog_rdata, FB);
    reset_with(3'h4);
    chk(reset_src, 32'h0);
    chk(watchdog_enable_ctl, 32'h0);
    chk(boot_select_ctl, 32'h1);
    chk(df_start_o, df_exp(1'b0, bnd));
    chk(min_program_o, 32'h0);
    chk(ram_rdata, v);
    rd(rscl_pkg::ADDR_POWER_CONTROL);
    chk(bus_rdata, rscl_pkg::POWER_CTL_POR);
    wr(rscl_pkg::ADDR_POWER_CONTROL, 8'hFF);
    reset_with(3'h2);
    chk(reset_src, 32'h1);
    chk(watchdog_enable_ctl, 32'h1);
    rd(rscl_pkg::ADDR_POWER_CONTROL);
    chk(bus_rdata, rscl_pkg::POWER_CTL_KEEP);
    reset_with(3'h1);
    chk(reset_src, 32'h3);
    wr(rscl_pkg::ADDR_FLASH_BOUNDARY, 8'h12);
    rd(rscl_pkg::ADDR_FLASH_BOUNDARY);
    chk(bus_rdata, bnd);
    keys();
    wr(rscl_pkg::ADDR_FLASH_BOUNDARY, 8'h12);
    rd(rscl_pkg::ADDR_FLASH_BOUNDARY);
    chk(bus_rdata, 32'h12);
    // Second key late: the pair must not open the gate
    wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_FIRST);
    repeat (40) @(negedge mclk);
    wr(rscl_pkg::ADDR_TIMED_ACCESS, rscl_pkg::KEY_SECOND);
    wr(rscl_pkg::ADDR_FLASH_BOUNDARY, 8'h34);
    rd(rscl_pkg::ADDR_FLASH_BOUNDARY);
    chk(bus_rdata, 32'h12);
    keys();
    wr(rscl_pkg::ADDR_CHIP_CONTROL, 8'h00);
    chk(boot_select_ctl, 32'h0);
    keys();
    wr(rscl_pkg::ADDR_CHIP_CONTROL, 8'h80);
    chk(sw_reset_req, 32'h1);
    reset_with(3'h0);
    chk(reset_src, 32'h2);
    chk(boot_select_ctl, 32'h0);
    chk(sw_reset_req, 32'h0);
    // External reset: pin held across release, boot reloads from config
    ext_pin = 1'b1;
    reset_with(3'h0);
    ext_pin = 1'b0;
    chk(reset_src, 32'h2);
    chk(boot_select_ctl, 32'h1);
    rd(rscl_pkg::ADDR_FLASH_BOUNDARY);
    chk(bus_rdata, bnd);
    pr(3'h2, 2'h0, 8'hFD);
    pr(3'h1, 2'h0, 8'h00);
    chk(prog_rdata, 32'hFF);
    pr(3'h0, 2'h0, 8'h00);
    chk(prog_rdata, 32'h7C);
    pr(3'h2, 2'h1, 8'h00);
    pr(3'h0, 2'h1, 8'h00);
    chk(prog_rdata, bnd);
    @(negedge mclk);
    isp_rd = 1'b1;
    @(negedge mclk);
    isp_rd = 1'b0;
    chk(isp_rdata, FB);
    pr(3'h4, 2'h0, 8'h00);
    chk(cfg_o, 32'hFFFF_FFFF);
    pr(3'h1, 2'h0, 8'h00);
    chk(prog_rdata, FB);
    reset_with(3'h4);
    chk(df_start_o, df_exp(1'b1, bnd));
    pr(3'h2, 2'h0, 8'h7E);
    pr(3'h2, 2'h1, 8'h00);
    reset_with(3'h4);
    chk(min_program_o, 32'h1);
    chk(df_start_o, df_exp(1'b0, 8'h00));
    conclude();
  end
endmodule : testbench
`default_nettype wire
